// >>> rtl/acm_pkg.sv
// constants for the aux3 and microphone mixer control registers
package acm_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam int          ACM_ADDR_W      = 12;
    localparam logic [7:0]  ACM_AUX3_INDEX  = 8'h06;
    localparam logic [7:0]  ACM_MIC_INDEX   = 8'h07;
    localparam logic [11:0] ACM_AUX3_ADDR   = {2'b00, ACM_AUX3_INDEX, 2'b00};
    localparam logic [11:0] ACM_MIC_ADDR    = {2'b00, ACM_MIC_INDEX, 2'b00};
    localparam logic [11:0] ACM_PWR_ADDR    = 12'h040;
    localparam logic [11:0] ACM_STAT_ADDR   = 12'h044;

    // ------------------------------------------------------------
    // mixer register layout and reset value
    // ------------------------------------------------------------
    localparam int          ACM_LMUTE_BIT   = 15;
    localparam int          ACM_LGAIN_MSB   = 12;
    localparam int          ACM_LGAIN_LSB   = 8;
    localparam int          ACM_RMUTE_BIT   = 7;
    localparam int          ACM_RGAIN_MSB   = 4;
    localparam int          ACM_RGAIN_LSB   = 0;
    localparam logic [15:0] ACM_MIX_RESET   = 16'h8888;
    localparam logic [15:0] ACM_MIX_WMASK   = 16'h9F9F;

    // ------------------------------------------------------------
    // power control and status layout
    // ------------------------------------------------------------
    localparam int          ACM_CONV_OFF_BIT = 0;
    localparam int          ACM_AIN_EN_BIT   = 1;
    localparam int          ACM_ANA_EN_BIT   = 2;
    localparam logic [2:0]  ACM_PWR_RESET    = 3'h0;
    localparam int          ACM_ST_LOCK_BIT  = 0;
    localparam int          ACM_ST_DROP_BIT  = 5;

endpackage

// >>> rtl/acm_mix_if.sv
// write and value path between the bus front end and one mixer register
`timescale 1ns/1ps
`default_nettype none

interface acm_mix_if;
    logic        wr_en;
    logic [15:0] wr_data;
    logic        lock;
    logic [15:0] value;

    modport ctrl  (output wr_en, output wr_data, output lock, input value);
    modport store (input wr_en, input wr_data, input lock, output value);
endinterface

`default_nettype wire

// >>> rtl/acm_mix_reg.sv
// one 16-bit mixer control register with forced-default lock
`timescale 1ns/1ps
`default_nettype none

module acm_mix_reg
    import acm_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // register access
    acm_mix_if.store  port_if
);

    logic [15:0] value_reg;
    logic [15:0] value_next;

    // lock wins over a write in the same cycle; dropped, not queued
    assign value_next = port_if.lock  ? ACM_MIX_RESET :              // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16]
                        port_if.wr_en ? (port_if.wr_data & ACM_MIX_WMASK) :
                                        value_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= ACM_MIX_RESET;                               // [RULE10] [RULE11]
        end else begin
            value_reg <= value_next;
        end
    end

    assign port_if.value = value_reg;

endmodule

`default_nettype wire

// >>> rtl/acm_lock.sv
// combines the power-down conditions into the mixer write lock
`timescale 1ns/1ps
`default_nettype none

module acm_lock
    import acm_pkg::*;
(
    // conditions
    input  wire logic       power_down_pin_n,
    input  wire logic [2:0] pwr_ctrl,
    // result
    output var  logic       lock,
    output var  logic [3:0] cause
);

    // evaluated every cycle, no memory: release is immediate
    assign cause[0] = ~power_down_pin_n;                              // [RULE12]
    assign cause[1] = pwr_ctrl[ACM_CONV_OFF_BIT];                     // [RULE13]
    assign cause[2] = ~pwr_ctrl[ACM_AIN_EN_BIT];                      // [RULE14]
    assign cause[3] = ~pwr_ctrl[ACM_ANA_EN_BIT];                      // [RULE15]
    assign lock     = |cause;                                         // [RULE16]

endmodule

`default_nettype wire

// >>> rtl/acm_mixer_regs.sv
// apb register bank for the aux3 and microphone mixer controls
//
// Behaviour
// [RULE1] aux3 bit 15 is the left mute: 0 mixes, 1 mutes.
// [RULE2] aux3 bits 12:8 are left gain, -1.5 dB a step, 01000 unity.
// [RULE3] aux3 bit 7 is the right mute: 0 mixes, 1 mutes.
// [RULE4] aux3 bits 4:0 are right gain with the same step code.
// [RULE5] mic bit 15 is the left microphone mute: 0 mixes, 1 mutes.
// [RULE6] mic bits 12:8 are left microphone gain, +12 dB down to -34.5 dB.
// [RULE7] mic bit 7 is the right microphone mute: 0 mixes, 1 mutes.
// [RULE8] mic bits 4:0 are right microphone gain, 01000 unity.
// [RULE9] software writes zero to bits 14, 13, 6 and 5 of both registers.
// [RULE10] both registers reset to 0x8888.
// [RULE11] while reset is low both registers sit at default, no writes.
// [RULE12] while the power-down pin is low both stay default, no writes.
// [RULE13] while all conversions are off both stay default, no writes.
// [RULE14] while analog-in-to-mixer is disabled both stay default.
// [RULE15] while the analog channels are disabled both stay default.
// [RULE16] the lock is checked every cycle and locked writes are dropped.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module acm_mixer_regs
    import acm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // power-down pin
    input  wire logic        power_down_pin_n,
    // aux3 mixer controls
    output var  logic        left_aux3_mute,
    output var  logic [4:0]  left_aux3_gain,
    output var  logic        right_aux3_mute,
    output var  logic [4:0]  right_aux3_gain,
    // microphone mixer controls
    output var  logic        left_microphone_mute,
    output var  logic [4:0]  left_microphone_gain,
    output var  logic        right_microphone_mute,
    output var  logic [4:0]  right_microphone_gain
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic [2:0]  pwr_reg;
    logic [2:0]  pwr_next;
    logic        drop_reg;
    logic        drop_next;

    acm_mix_if   aux3_if ();
    acm_mix_if   mic_if ();

    logic        lock;
    logic [3:0]  lock_cause;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic        setup;
    logic        done;
    logic        hit_aux3;
    logic        hit_mic;
    logic        hit_pwr;
    logic        hit_stat;
    logic        mapped;
    logic        wr_done;
    logic        wr_mix;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;

    assign setup    = psel & ~penable;
    // no wait state: pready is high in the access cycle right after setup
    assign done     = psel & penable & pready_reg;
    assign hit_aux3 = (paddr == ACM_AUX3_ADDR);
    assign hit_mic  = (paddr == ACM_MIC_ADDR);
    assign hit_pwr  = (paddr == ACM_PWR_ADDR);
    assign hit_stat = (paddr == ACM_STAT_ADDR);
    assign mapped   = hit_aux3 | hit_mic | hit_pwr | hit_stat;
    assign wr_done  = done & pwrite & ~pslverr_reg;
    assign wr_mix   = wr_done & (hit_aux3 | hit_mic);

    // ------------------------------------------------------------
    // write lock
    // ------------------------------------------------------------
    acm_lock u_lock (
        .power_down_pin_n (power_down_pin_n),
        .pwr_ctrl         (pwr_reg),
        .lock             (lock),
        .cause            (lock_cause)
    );

    // reserved bits are masked inside the register, so a careless
    // write of ones there still reads back as zero
    assign aux3_if.wr_en   = wr_done & hit_aux3;                     // [RULE16]
    assign aux3_if.wr_data = pwdata[15:0];                           // [RULE9]
    assign aux3_if.lock    = lock;
    assign mic_if.wr_en    = wr_done & hit_mic;                      // [RULE16]
    assign mic_if.wr_data  = pwdata[15:0];                           // [RULE9]
    assign mic_if.lock     = lock;

    // ------------------------------------------------------------
    // mixer registers
    // ------------------------------------------------------------
    acm_mix_reg u_aux3 (
        .pclk    (pclk),
        .presetn (presetn),
        .port_if (aux3_if.store)
    );

    acm_mix_reg u_mic (
        .pclk    (pclk),
        .presetn (presetn),
        .port_if (mic_if.store)
    );

    // field outputs are slices of the register flops
    assign left_aux3_mute  = aux3_if.value[ACM_LMUTE_BIT];           // [RULE1]
    assign left_aux3_gain  =
        aux3_if.value[ACM_LGAIN_MSB:ACM_LGAIN_LSB];                  // [RULE2]
    assign right_aux3_mute = aux3_if.value[ACM_RMUTE_BIT];           // [RULE3]
    assign right_aux3_gain =
        aux3_if.value[ACM_RGAIN_MSB:ACM_RGAIN_LSB];                  // [RULE4]

    assign left_microphone_mute  = mic_if.value[ACM_LMUTE_BIT];      // [RULE5]
    assign left_microphone_gain  =
        mic_if.value[ACM_LGAIN_MSB:ACM_LGAIN_LSB];                   // [RULE6]
    assign right_microphone_mute = mic_if.value[ACM_RMUTE_BIT];      // [RULE7]
    assign right_microphone_gain =
        mic_if.value[ACM_RGAIN_MSB:ACM_RGAIN_LSB];                   // [RULE8]

    // ------------------------------------------------------------
    // power control and dropped-write flag
    // ------------------------------------------------------------
    assign pwr_next  = (wr_done & hit_pwr) ? pwdata[2:0] : pwr_reg;

    // set wins over the write-one clear in the same cycle
    assign drop_next = (wr_mix & lock) ? 1'b1 :                      // [RULE16]
                       (wr_done & hit_stat & pwdata[ACM_ST_DROP_BIT])
                           ? 1'b0 : drop_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg  <= ACM_PWR_RESET;
            drop_reg <= 1'b0;
        end else begin
            pwr_reg  <= pwr_next;
            drop_reg <= drop_next;
        end
    end

    // ------------------------------------------------------------
    // read data and bus answer
    // ------------------------------------------------------------
    assign stat_word = {26'h0, drop_reg, lock_cause, lock};

    assign rd_mux = hit_aux3 ? {16'h0, aux3_if.value} :
                    hit_mic  ? {16'h0, mic_if.value}  :
                    hit_pwr  ? {29'h0, pwr_reg}       :
                    hit_stat ? stat_word              :
                               32'h0;

    // read data is sampled in the setup cycle, at the same edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            prdata_reg  <= (setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

endmodule

`default_nettype wire

// >>> testbench/acm_mixer_regs_monitor.sv
// port assertions for the mixer register bank
`timescale 1ns/1ps
`default_nettype none
module acm_mixer_regs_monitor
    import acm_pkg::*;
(
    // clock, reset, apb and pin
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        power_down_pin_n,
    // mixer controls
    input wire logic        left_aux3_mute,
    input wire logic [4:0]  left_aux3_gain,
    input wire logic        right_aux3_mute,
    input wire logic [4:0]  right_aux3_gain,
    input wire logic        left_microphone_mute,
    input wire logic [4:0]  left_microphone_gain,
    input wire logic        right_microphone_mute,
    input wire logic [4:0]  right_microphone_gain
);
    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    logic [15:0] aux_v;
    logic [15:0] mic_v;
    logic [15:0] wd_q;
    logic        wr;
    logic        dflt;
    assign aux_v = {left_aux3_mute, 2'b00, left_aux3_gain,
                    right_aux3_mute, 2'b00, right_aux3_gain};
    assign mic_v = {left_microphone_mute, 2'b00, left_microphone_gain,
                    right_microphone_mute, 2'b00, right_microphone_gain};
    assign wr = psel && penable && pready && pwrite;
    assign dflt = aux_v == ACM_MIX_RESET && mic_v == ACM_MIX_RESET;
    // keeps the data of a taken write for the cycle after it
    always_ff @(posedge pclk) begin
        wd_q <= pwdata[15:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst_dflt;
        $rose(presetn) |-> dflt;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt)
        else $error("not default after reset");
    property p_pin;
        !power_down_pin_n |=> dflt;
    endproperty
    a_pin: assert property (p_pin)
        else $error("not default while pin low");
    property p_aux_l;
        wr && paddr == ACM_AUX3_ADDR |=>
            aux_v[15:8] == (wd_q[15:8] & 8'h9F) || dflt;
    endproperty
    a_aux_l: assert property (p_aux_l)
        else $error("aux3 left field wrong");
    property p_aux_r;
        wr && paddr == ACM_AUX3_ADDR |=>
            aux_v[7:0] == (wd_q[7:0] & 8'h9F) || dflt;
    endproperty
    a_aux_r: assert property (p_aux_r)
        else $error("aux3 right field wrong");
    property p_mic_l;
        wr && paddr == ACM_MIC_ADDR |=>
            mic_v[15:8] == (wd_q[15:8] & 8'h9F) || dflt;
    endproperty
    a_mic_l: assert property (p_mic_l)
        else $error("mic left field wrong");
    property p_mic_r;
        wr && paddr == ACM_MIC_ADDR |=>
            mic_v[7:0] == (wd_q[7:0] & 8'h9F) || dflt;
    endproperty
    a_mic_r: assert property (p_mic_r)
        else $error("mic right field wrong");
    property p_hold;
        !(wr && (paddr == ACM_AUX3_ADDR || paddr == ACM_MIC_ADDR)) |=>
            ($stable(aux_v) && $stable(mic_v)) || dflt;
    endproperty
    a_hold: assert property (p_hold)
        else $error("mixer value changed without write");
    property p_rd_aux;
        pready && !pwrite && !pslverr && paddr == ACM_AUX3_ADDR |->
            prdata == {16'h0000, $past(aux_v)};
    endproperty
    a_rd_aux: assert property (p_rd_aux)
        else $error("aux3 read data wrong");
    property p_rd_mic;
        pready && !pwrite && !pslverr && paddr == ACM_MIC_ADDR |->
            prdata == {16'h0000, $past(mic_v)};
    endproperty
    a_rd_mic: assert property (p_rd_mic)
        else $error("mic read data wrong");
endmodule

bind acm_mixer_regs acm_mixer_regs_monitor acm_mixer_regs_monitor_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_pin_n(power_down_pin_n),
    .left_aux3_mute(left_aux3_mute), .left_aux3_gain(left_aux3_gain),
    .right_aux3_mute(right_aux3_mute), .right_aux3_gain(right_aux3_gain),
    .left_microphone_mute(left_microphone_mute),
    .left_microphone_gain(left_microphone_gain),
    .right_microphone_mute(right_microphone_mute),
    .right_microphone_gain(right_microphone_gain));
`default_nettype wire

// >>> testbench/acm_mixer_regs_tb.sv
// self-checking bench for the mixer register bank
`timescale 1ns/1ps
`default_nettype none
module acm_mixer_regs_tb
    import acm_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pd_n = 1, pready, pslverr, err;
    logic        lam, ram, lmm, rmm;
    logic [4:0]  lag, rag, lmg, rmg;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    int          fail_count = 0, n_tests = 0;
    wire  [31:0] aux_o = {16'h0, lam, 2'b00, lag, ram, 2'b00, rag};
    wire  [31:0] mic_o = {16'h0, lmm, 2'b00, lmg, rmm, 2'b00, rmg};
    always #12.5 pclk = ~pclk;
    acm_mixer_regs acm_mixer_regs_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_down_pin_n(pd_n),
        .left_aux3_mute(lam), .left_aux3_gain(lag),
        .right_aux3_mute(ram), .right_aux3_gain(rag),
        .left_microphone_mute(lmm), .left_microphone_gain(lmg),
        .right_microphone_mute(rmm), .right_microphone_gain(rmg));
    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge so psel never toggles in one step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // waits as long as the slave needs; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        apb(1'b0, ACM_AUX3_ADDR, 32'h0);
        chk(rd, {16'h0, ACM_MIX_RESET});
        apb(1'b0, ACM_MIC_ADDR, 32'h0);
        chk(rd, {16'h0, ACM_MIX_RESET});
        chk(mic_o, {16'h0, ACM_MIX_RESET});
        apb(1'b1, ACM_AUX3_ADDR, 32'h0);
        chk(aux_o, {16'h0, ACM_MIX_RESET});
    endtask
    task automatic t_fields;
        logic [15:0] v[3] = '{16'h9F9F, 16'h0108, 16'h1700};
        logic [15:0] m;
        apb(1'b1, ACM_PWR_ADDR, 32'h6);
        foreach (v[i]) begin
            // reserved bits are always written as zero
            m = v[i] ^ ACM_MIX_WMASK;
            apb(1'b1, ACM_AUX3_ADDR, {16'h0, v[i]});
            apb(1'b1, ACM_MIC_ADDR, {16'h0, m});
            chk(aux_o, {16'h0, v[i]});
            chk(mic_o, {16'h0, m});
            apb(1'b0, ACM_MIC_ADDR, 32'h0);
            chk(rd, {16'h0, m});
            apb(1'b0, ACM_AUX3_ADDR, 32'h0);
            chk(rd, {16'h0, v[i]});
        end
    endtask
    task automatic t_locks;
        logic [2:0] pw[4] = '{3'h6, 3'h7, 3'h4, 3'h2};
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ACM_AUX3_ADDR, 32'h0107);
            apb(1'b1, ACM_MIC_ADDR, 32'h0107);
            chk(aux_o, 32'h0107);
            if (c == 0) pd_n <= 1'b0;
            apb(1'b1, ACM_PWR_ADDR, {29'h0, pw[c]});
            apb(1'b1, ACM_AUX3_ADDR, 32'h0000);
            chk(aux_o, 32'h8888);
            chk(mic_o, 32'h8888);
            // dropped write is flagged next to the active lock cause
            apb(1'b0, ACM_STAT_ADDR, 32'h0);
            chk(rd, 32'h21 | (32'h2 << c));
            apb(1'b1, ACM_STAT_ADDR, 32'h20);
            pd_n <= 1'b1;
            apb(1'b1, ACM_PWR_ADDR, 32'h6);
            chk(aux_o, 32'h8888);
            apb(1'b0, ACM_STAT_ADDR, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    task automatic t_bad;
        apb(1'b1, ACM_AUX3_ADDR, 32'h0101);
        apb(1'b1, 12'h01A, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(aux_o, 32'h0101);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_midrst;
        presetn <= 1'b0;
        @(posedge pclk);
        chk(aux_o, 32'h8888);
        chk(mic_o, 32'h8888);
        presetn <= 1'b1;
        @(posedge pclk);
        // power control is back at zero, so the lock is up again
        apb(1'b0, ACM_STAT_ADDR, 32'h0);
        chk(rd, 32'h19);
        apb(1'b1, ACM_MIC_ADDR, 32'h0107);
        chk(mic_o, 32'h8888);
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fields();
        t_locks();
        t_bad();
        t_midrst();
        results();
    end
    // whole run needs about 170 cycles
    initial begin
        #100000;
        $display("ERROR %0t watchdog expired", $time);
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
